// ===== hw/eeprom_link_defs.svh
/*
 * Constants of the two-wire slave front end: address pattern, bit counts,
 * self-timed program time.
 * Assumes a 20 MHz core clock; included by its bare name.
 */
`ifndef EEPROM_LINK_DEFS_SVH
`define EEPROM_LINK_DEFS_SVH

`define FAMILY_PATTERN 4'hA
`define BITS_PER_WORD 4'h8
`define ACK_BIT_INDEX 4'h8
`define CLK_PERIOD_NS 50
`define PROGRAM_TIME_MS 5
`define PROGRAM_CYCLES ((`PROGRAM_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RW_READ 1'b1

`endif

// ===== hw/eeprom_link_pkg.sv
/*
 * Types of the two-wire slave front end.
 * Assumes eeprom_link_defs.svh is available to the compile.
 */
`default_nettype none

package eeprom_link_pkg;
	typedef enum logic [5:0] {
		ST_STANDBY = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK = 6'h04,
		ST_RX = 6'h08,
		ST_TX = 6'h10,
		ST_TX_ACK = 6'h20
	} link_state_t;

	typedef enum logic [0:0] {
		DENSITY_SMALL = 1'b0,
		DENSITY_LARGE = 1'b1
	} density_t;
endpackage : eeprom_link_pkg

`default_nettype wire

// ===== hw/pin_sync.sv
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input is from outside the CLK domain.
 */
`default_nettype none

module pin_sync #(
	parameter logic RESET_VALUE = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// the first stage is read by the second stage only
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			meta_q <= meta_d;
			sync_out <= sync_d;
		end
	end
endmodule : pin_sync

`default_nettype wire

// ===== hw/eeprom_link.sv
/*
 * Slave-side two-wire protocol front end of a small serial EEPROM: start and
 * stop detection, device address match, byte receive and transmit with
 * ninth-clock acknowledge, and the self-timed program cycle.
 * Assumes the serial clock and data pins are asynchronous and much slower
 * than CLK; the memory array sits outside on the user-side ports.
 */
`default_nettype none
`include "eeprom_link_defs.svh"

module eeprom_link
	import eeprom_link_pkg::*;
#(
	parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	input wire logic CHIP_SELECT_HIGH_PIN,
	input wire logic CHIP_SELECT_MID_PIN,
	input wire logic CHIP_SELECT_LOW_PIN,
	input wire eeprom_link_pkg::density_t DENSITY,
	input wire logic [7:0] TX_DATA,
	output logic [7:0] RX_DATA,
	output logic RX_VALID,
	output logic TX_TAKEN,
	output logic SELECTED,
	output logic READ_MODE,
	output logic [1:0] PAGE_BITS,
	output logic PROGRAMMING,
	output logic STANDBY
);
	import eeprom_link_pkg::*;

	localparam int CNT_W = $clog2(PROGRAM_CYCLES + 1);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic scl_prev_q;
	logic sda_prev_q;
	logic sel_hi_s;
	logic sel_mid_s;
	logic density_s;

	pin_sync #(.RESET_VALUE(1'b1)) u_scl_sync (
		.clk(CLK),
		.reset(RESET),
		.async_in(SCL),
		.sync_out(scl_s)
	);

	pin_sync #(.RESET_VALUE(1'b1)) u_sda_sync (
		.clk(CLK),
		.reset(RESET),
		.async_in(SDA_IN),
		.sync_out(sda_s)
	);

	// straps are pins as well; they sit still, so two flops are enough
	pin_sync #(.RESET_VALUE(1'b0)) u_sel_hi_sync (
		.clk(CLK), .reset(RESET), .async_in(CHIP_SELECT_HIGH_PIN), .sync_out(sel_hi_s)
	);
	pin_sync #(.RESET_VALUE(1'b0)) u_sel_mid_sync (
		.clk(CLK), .reset(RESET), .async_in(CHIP_SELECT_MID_PIN), .sync_out(sel_mid_s)
	);
	pin_sync #(.RESET_VALUE(1'b0)) u_density_sync (
		.clk(CLK), .reset(RESET), .async_in(DENSITY), .sync_out(density_s)
	);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// ------------------------------------------------------------
	// condition and edge detection
	// ------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	always_comb begin
		scl_rise = scl_s & ~scl_prev_q;
		scl_fall = ~scl_s & scl_prev_q;
		// a data edge while the clock stays high is never data
		start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
		stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	end

	// ------------------------------------------------------------
	// address match
	// ------------------------------------------------------------
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic addr_match;

	always_comb begin
		addr_match = (shift_q[7:4] == `FAMILY_PATTERN);
		if (density_s == DENSITY_SMALL) begin
			// low select pin unused, bit 1 is a page bit
			addr_match = addr_match & (shift_q[3] == sel_hi_s)
				& (shift_q[2] == sel_mid_s);
		end else begin
			addr_match = addr_match & (shift_q[3] == sel_hi_s);
		end
	end

	// ------------------------------------------------------------
	// protocol state machine
	// ------------------------------------------------------------
	link_state_t state_q;
	link_state_t state_d;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic sda_oe_n_d;
	logic sda_out_d;
	logic [7:0] rx_data_d;
	logic rx_valid_d;
	logic tx_taken_d;
	logic selected_d;
	logic read_mode_d;
	logic [1:0] page_bits_d;
	logic wrote_q;
	logic wrote_d;
	logic prog_start;
	logic [CNT_W-1:0] prog_cnt_q;
	logic [CNT_W-1:0] prog_cnt_d;
	logic programming_d;
	logic standby_d;
	logic master_ack_q;
	logic master_ack_d;

	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		sda_oe_n_d = SDA_OE_N;
		sda_out_d = 1'b0;
		rx_data_d = RX_DATA;
		rx_valid_d = 1'b0;
		tx_taken_d = 1'b0;
		selected_d = SELECTED;
		read_mode_d = READ_MODE;
		page_bits_d = PAGE_BITS;
		wrote_d = wrote_q;
		master_ack_d = master_ack_q;
		prog_start = 1'b0;
		if (PROGRAMMING) begin
			// all pin activity ignored until the cycle ends
			state_d = ST_STANDBY;
			sda_oe_n_d = 1'b1;
			selected_d = 1'b0;
		end else if (stop_seen) begin
			state_d = ST_STANDBY;
			sda_oe_n_d = 1'b1;
			selected_d = 1'b0;
			prog_start = wrote_q;
			wrote_d = 1'b0;
		end else if (start_seen) begin
			state_d = ST_ADDR;
			bit_cnt_d = 4'h0;
			// a repeated start abandons a write: no program cycle from it
			wrote_d = 1'b0;
			sda_oe_n_d = 1'b1;
			selected_d = 1'b0;
		end else begin
			case (state_q)
				ST_STANDBY: begin
					sda_oe_n_d = 1'b1;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == `BITS_PER_WORD) begin
						if (state_q == ST_ADDR && !addr_match) begin
							state_d = ST_STANDBY;
						end else begin
							state_d = ST_ACK;
							sda_oe_n_d = 1'b0;
							if (state_q == ST_ADDR) begin
								selected_d = 1'b1;
								read_mode_d = (shift_q[0] == `RW_READ);
								page_bits_d = (density_s == DENSITY_SMALL)
									? {1'b0, shift_q[1]} : shift_q[2:1];
							end else begin
								rx_data_d = shift_q;
								rx_valid_d = 1'b1;
								wrote_d = 1'b1;
							end
						end
					end
				end
				ST_ACK: begin
					// release after the ninth clock's falling edge, or put TX_DATA[7] out in a read
					if (scl_fall) begin
						bit_cnt_d = 4'h0;
						if (READ_MODE) begin
							state_d = ST_TX;
							shift_d = {TX_DATA[6:0], 1'b0};
							sda_oe_n_d = TX_DATA[7];
							tx_taken_d = 1'b1;
							bit_cnt_d = 4'h1;
						end else begin
							state_d = ST_RX;
							sda_oe_n_d = 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_q == `BITS_PER_WORD) begin
							state_d = ST_TX_ACK;
							sda_oe_n_d = 1'b1;
						end else begin
							sda_oe_n_d = shift_q[7];
							shift_d = {shift_q[6:0], 1'b0};
							bit_cnt_d = bit_cnt_q + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						master_ack_d = ~sda_s;
					end else if (scl_fall) begin
						if (master_ack_q) begin
							state_d = ST_TX;
							shift_d = {TX_DATA[6:0], 1'b0};
							sda_oe_n_d = TX_DATA[7];
							tx_taken_d = 1'b1;
							bit_cnt_d = 4'h1;
						end else begin
							// no ack: wait idle for the stop
							state_d = ST_STANDBY;
							selected_d = 1'b0;
						end
					end
				end
				default: begin
					state_d = ST_STANDBY;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// self-timed program cycle
	// ------------------------------------------------------------
	always_comb begin
		prog_cnt_d = prog_cnt_q;
		programming_d = PROGRAMMING;
		if (prog_start) begin
			prog_cnt_d = CNT_W'(PROGRAM_CYCLES - 1);
			programming_d = 1'b1;
		end else if (PROGRAMMING) begin
			if (prog_cnt_q == '0) begin
				programming_d = 1'b0;
			end else begin
				prog_cnt_d = prog_cnt_q - CNT_W'(1);
			end
		end
		standby_d = (state_d == ST_STANDBY) & ~programming_d;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_q <= ST_STANDBY;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			SDA_OE_N <= 1'b1;
			SDA_OUT <= 1'b0;
			RX_DATA <= 8'h00;
			RX_VALID <= 1'b0;
			TX_TAKEN <= 1'b0;
			SELECTED <= 1'b0;
			READ_MODE <= 1'b0;
			PAGE_BITS <= 2'h0;
			wrote_q <= 1'b0;
			master_ack_q <= 1'b0;
			prog_cnt_q <= '0;
			PROGRAMMING <= 1'b0;
			STANDBY <= 1'b1;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			SDA_OE_N <= sda_oe_n_d;
			SDA_OUT <= sda_out_d;
			RX_DATA <= rx_data_d;
			RX_VALID <= rx_valid_d;
			TX_TAKEN <= tx_taken_d;
			SELECTED <= selected_d;
			READ_MODE <= read_mode_d;
			PAGE_BITS <= page_bits_d;
			wrote_q <= wrote_d;
			master_ack_q <= master_ack_d;
			prog_cnt_q <= prog_cnt_d;
			PROGRAMMING <= programming_d;
			STANDBY <= standby_d;
		end
	end
endmodule : eeprom_link

`default_nettype wire

// ===== test/eeprom_link_props.sv
/* Protocol checker of the two-wire slave front end.
   Assumes it is bound to eeprom_link and the link clock is far slower than CLK. */
`default_nettype none
module eeprom_link_props
	import eeprom_link_pkg::*;
#(
	parameter int PROGRAM_CYCLES = 100000
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic SCL,
	input wire logic SDA_OE_N,
	input wire eeprom_link_pkg::density_t DENSITY,
	input wire logic RX_VALID,
	input wire logic TX_TAKEN,
	input wire logic SELECTED,
	input wire logic READ_MODE,
	input wire logic [1:0] PAGE_BITS,
	input wire logic PROGRAMMING,
	input wire logic STANDBY
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// program cycle length
	// ----
	int prog_cnt_q;
	int prog_cnt_d;
	always_comb begin
		prog_cnt_d = PROGRAMMING ? prog_cnt_q + 1 : 0;
	end
	always_ff @(posedge CLK) begin
		prog_cnt_q <= RESET ? 0 : prog_cnt_d;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_pull;
		$fell(SDA_OE_N);
	endsequence
	sequence s_hold;
		!SDA_OE_N [*4];
	endsequence
	property p_pull_hold; s_pull |-> s_hold; endproperty
	property p_reset_state; $fell(RESET) |-> SDA_OE_N && STANDBY && !PROGRAMMING; endproperty
	property p_prog_len; $fell(PROGRAMMING) |-> prog_cnt_q == PROGRAM_CYCLES; endproperty
	property p_prog_quiet; PROGRAMMING |-> SDA_OE_N && !RX_VALID; endproperty
	property p_prog_end; $fell(PROGRAMMING) |-> ##[0:2] STANDBY; endproperty
	property p_standby; STANDBY |-> !SELECTED && !PROGRAMMING; endproperty
	property p_rx_write; RX_VALID |-> SELECTED && !READ_MODE; endproperty
	property p_tx_read; TX_TAKEN |-> SELECTED && READ_MODE; endproperty
	// pin may only move while the master holds the clock low
	property p_oe_scl_low; $changed(SDA_OE_N) |-> !$past(SCL); endproperty
	property p_page_small; SELECTED && DENSITY == DENSITY_SMALL |-> !PAGE_BITS[1]; endproperty
	a_pull_hold: assert property (p_pull_hold) else $error("ack or bit too short");
	a_reset_state: assert property (p_reset_state) else $error("bad reset state");
	a_prog_len: assert property (p_prog_len) else $error("program length");
	a_prog_quiet: assert property (p_prog_quiet) else $error("answer while busy");
	a_prog_end: assert property (p_prog_end) else $error("no standby after program");
	a_standby: assert property (p_standby) else $error("standby while active");
	a_rx_write: assert property (p_rx_write) else $error("byte outside write");
	a_tx_read: assert property (p_tx_read) else $error("load outside read");
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
	a_page_small: assert property (p_page_small) else $error("page bits small");
endmodule : eeprom_link_props
`default_nettype wire

// ===== test/eeprom_master.sv
/* Two-wire bus master model: start, stop, nine-bit transfers, recovery.
   Assumes the bench resolves the open-drain wire and feeds it back. */
`default_nettype none
module eeprom_master (
	input wire logic clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// link primitives
	// ----
	initial begin
		scl = 1'h1;
		sda = 1'h1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_clk
	// data set one cycle after the fall keeps hold time on the slow side
	task automatic bit_io(input logic b, output logic r);
		wait_clk(1);
		sda <= b;
		wait_clk(3);
		scl <= 1'h1;
		wait_clk(3);
		r = sda_w;
		wait_clk(1);
		scl <= 1'h0;
	endtask : bit_io
	task automatic start();
		wait_clk(1);
		sda <= 1'h1;
		wait_clk(3);
		scl <= 1'h1;
		wait_clk(4);
		sda <= 1'h0;
		wait_clk(4);
		scl <= 1'h0;
	endtask : start
	// clock is left standing high after a stop
	task automatic stop();
		wait_clk(1);
		sda <= 1'h0;
		wait_clk(3);
		scl <= 1'h1;
		wait_clk(4);
		sda <= 1'h1;
		wait_clk(8);
	endtask : stop
	// msb first; bit 0 is the ack slot, 0 from the master keeps a read going
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			bit_io(w[i], r[i]);
		end
	endtask : xfer
	task automatic recover();
		logic r;
		r = 1'h0;
		for (int i = 0; i < 9 && !r; i++) begin
			bit_io(1'h1, r);
		end
		start();
	endtask : recover
endmodule : eeprom_master
`default_nettype wire

// ===== test/eeprom_link_tb_top.sv
/* Self-checking bench of the two-wire slave front end.
   Assumes eeprom_master drives the link and the checker is bound below. */
`default_nettype none
module eeprom_link_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import eeprom_link_pkg::*;
	// ----
	// harness
	// ----
	localparam int PROG = 200;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic hi_pin = 1'h1;
	logic mid_pin = 1'h0;
	logic lo_pin = 1'h1;
	density_t density = DENSITY_SMALL;
	logic [7:0] tx_data = 8'h5A;
	logic [7:0] rx_data;
	logic rx_valid, tx_taken, selected, read_mode, programming, standby, sda_out, sda_oe_n;
	logic [1:0] page_bits;
	logic [8:0] r;
	wire scl, m_sda, sda_w;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int rx_pulses = 0;
	int tx_pulses = 0;
	assign sda_w = m_sda & (sda_oe_n | sda_out);
	always #25 clk = ~clk;
	eeprom_link #(.PROGRAM_CYCLES(PROG)) u_dut (.CLK(clk), .RESET(reset), .SCL(scl),
		.SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
		.CHIP_SELECT_HIGH_PIN(hi_pin), .CHIP_SELECT_MID_PIN(mid_pin),
		.CHIP_SELECT_LOW_PIN(lo_pin), .DENSITY(density), .TX_DATA(tx_data),
		.RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_TAKEN(tx_taken), .SELECTED(selected),
		.READ_MODE(read_mode), .PAGE_BITS(page_bits), .PROGRAMMING(programming),
		.STANDBY(standby));
	eeprom_master u_master (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(m_sda));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cycles++;
		if (rx_valid) rx_pulses++;
		if (tx_taken) tx_pulses++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	// ----
	// scenarios
	// ----
	task automatic t_write();
		int n;
		u_master.start();
		u_master.xfer({8'hAA, 1'h1}, r);
		check(8'(r[0]), 8'h00);
		check({4'h0, selected, read_mode, page_bits}, 8'h09);
		u_master.xfer({8'hC3, 1'h1}, r);
		check(8'(r[0]), 8'h00);
		check(rx_data, 8'hC3);
		check(8'(rx_pulses), 8'h01);
		u_master.stop();
		check(8'(programming), 8'h01);
		u_master.start();
		u_master.xfer({8'hAA, 1'h1}, r);
		check(8'(r[0]), 8'h01);
		u_master.stop();
		for (n = 0; n < 300 && programming; n++) u_master.wait_clk(1);
		check(8'(n < PROG), 8'h01);
		u_master.wait_clk(2);
		check(8'(standby), 8'h01);
		$display("test write done");
	endtask : t_write
	task automatic t_mismatch();
		logic [7:0] bad [3] = '{8'hB8, 8'hA0, 8'hAC};
		foreach (bad[i]) begin
			u_master.start();
			u_master.xfer({bad[i], 1'h1}, r);
			check(8'(r[0]), 8'h01);
			check(8'(standby), 8'h01);
			u_master.stop();
		end
		$display("test mismatch done");
	endtask : t_mismatch
	task automatic t_read();
		density <= DENSITY_LARGE;
		u_master.start();
		u_master.xfer({4'hA, 4'hD, 1'h1}, r);
		check(8'(r[0]), 8'h00);
		check({4'h0, selected, read_mode, page_bits}, 8'h0E);
		u_master.xfer({8'hFF, 1'h0}, r);
		tx_data <= 8'hA5;
		check(r[8:1], 8'h5A);
		u_master.xfer({8'hFF, 1'h1}, r);
		check(r[8:1], 8'hA5);
		check(8'(tx_pulses), 8'h02);
		check(8'(sda_out), 8'h00);
		u_master.stop();
		check(8'({programming, standby}), 8'h01);
		density <= DENSITY_SMALL;
		$display("test read done");
	endtask : t_read
	// cut a read of zeros after two bits, so the device still holds the wire low
	task automatic t_recover();
		tx_data <= 8'h00;
		u_master.start();
		u_master.xfer({8'hAB, 1'h1}, r);
		check(8'(r[0]), 8'h00);
		u_master.bit_io(1'h1, r[1]);
		u_master.bit_io(1'h1, r[0]);
		check(8'(r[1:0]), 8'h00);
		u_master.recover();
		u_master.xfer({8'hAA, 1'h1}, r);
		check(8'(r[0]), 8'h00);
		u_master.stop();
		check(8'({programming, standby}), 8'h01);
		$display("test recover done");
	endtask : t_recover
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		repeat (3) @(posedge clk);
		t_write();
		t_mismatch();
		t_read();
		t_recover();
		end_sim();
	end
endmodule : eeprom_link_tb_top
bind eeprom_link eeprom_link_props #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_props (
	.CLK(CLK), .RESET(RESET), .SCL(SCL), .SDA_OE_N(SDA_OE_N), .DENSITY(DENSITY),
	.RX_VALID(RX_VALID), .TX_TAKEN(TX_TAKEN), .SELECTED(SELECTED), .READ_MODE(READ_MODE),
	.PAGE_BITS(PAGE_BITS), .PROGRAMMING(PROGRAMMING), .STANDBY(STANDBY));
`default_nettype wire
